/* File: design/vsr_sysreg_bank.sv */
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - separate host/guest save registers and status word
// - maskable ack stores current or next PC
// - maskable ack copies status word to save
// - fatal ack stores current or next PC
// - fatal ack copies status word to save
// - status word holds flags and processor status
// - status word writes decided bit by bit
// - fatal PC/status registers need supervisor privilege
// - supervisor list of loadable group identifiers
// - restricted mode routes access, no software select
module vsr_sysreg_bank
    import vsr_pkg::*;
(
    input  wire logic        ref_clk_i,    // core clock, 20 MHz
    input  wire logic        rstn_i,       // async reset, active low
    input  wire logic        acc_req_i,    // register access request
    input  wire logic        acc_we_i,     // 1 write, 0 read
    input  wire logic [4:0]  acc_regid_i,  // register number
    input  wire logic [4:0]  acc_selid_i,  // selection group
    input  wire logic [31:0] acc_wdata_i,  // write data
    input  wire logic [1:0]  acc_priv_i,   // privilege of the access
    input  wire logic        guest_mode_i, // restricted mode, 1 guest
    input  wire logic        virt_enable_i,// virtualization enable
    input  wire logic        mexc_ack_i,   // maskable level acknowledge
    input  wire logic        fexc_ack_i,   // fatal level acknowledge
    input  wire logic [31:0] pc_cur_i,     // address of current insn
    input  wire logic [31:0] pc_next_i,    // address of next insn
    input  wire logic        pc_sel_next_i,// 1 save next, 0 current
    input  wire logic        flags_we_i,   // result flag update
    input  wire logic [4:0]  flags_i,      // new result flags
    output logic             done_o,       // access answered
    output logic             denied_o,     // access refused
    output logic      [31:0] rd_data_o,    // read data
    output logic      [31:0] host_program_status_o,  // host word
    output logic      [31:0] guest_program_status_o  // guest word
);

    ////////////////////////////////////////////////////////////////////////
    // decode of the number/group pair
    wire logic [9:0]  acc_key;
    wire logic [9:0]  dec;
    wire logic [2:0]  kind;
    wire logic [4:0]  mem_idx;
    wire logic [1:0]  need_raw;
    wire logic [1:0]  need;
    wire logic        mapped;
    wire logic        priv_ok;
    wire logic        sw_wr;
    wire logic        sup_or_above;

    assign acc_key  = {acc_selid_i, acc_regid_i};
    assign dec      = vsr_decode(acc_key);
    assign kind     = dec[9:7];
    assign mem_idx  = dec[6:2];
    assign need_raw = dec[1:0];
    assign mapped   = (kind != K_NONE);

    // snooze setup falls back to supervisor authority without virtualization
    assign need = (need_raw == PRIV_HYP && !virt_enable_i) ? PRIV_SUP
                : need_raw;
    // fatal save registers carry supervisor authority in both settings
    assign priv_ok      = (acc_priv_i >= need);
    assign sup_or_above = (acc_priv_i >= PRIV_SUP);
    assign sw_wr        = acc_req_i & acc_we_i & mapped & priv_ok;

    ////////////////////////////////////////////////////////////////////////
    // exception save address and status word bit mask
    wire logic [31:0] exc_pc;
    wire logic [31:0] psw_mask;
    wire logic [31:0] flag_word;

    assign exc_pc    = pc_sel_next_i ? pc_next_i : pc_cur_i;
    // user level writes reach only the result flags; reads return the whole word
    assign psw_mask  = sup_or_above ? 32'hffff_ffff : PSW_FLAGS;
    assign flag_word = {27'h000_0000, flags_i};

    ////////////////////////////////////////////////////////////////////////
    // host (index 0) and guest (index 1) copies
    logic [31:0] mpc_q [2];
    logic [31:0] mst_q [2];
    logic [31:0] fpc_q [2];
    logic [31:0] fst_q [2];
    logic [31:0] psw_q [2];

    wire logic        ctx;
    wire logic [31:0] psw_cur;

    assign ctx     = guest_mode_i;
    assign psw_cur = psw_q[ctx];

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ctx
            wire logic        hit;
            wire logic        wr_mpc;
            wire logic        wr_mst;
            wire logic        wr_fpc;
            wire logic        wr_fst;
            wire logic        wr_psw;
            wire logic [31:0] psw_sw;
            wire logic [31:0] next_mpc;
            wire logic [31:0] next_mst;
            wire logic [31:0] next_fpc;
            wire logic [31:0] next_fst;
            wire logic [31:0] next_psw;

            // only the copy of the running mode is touched
            assign hit    = (ctx == 1'(g));
            assign wr_mpc = hit & sw_wr & (kind == K_MPC);
            assign wr_mst = hit & sw_wr & (kind == K_MST);
            assign wr_fpc = hit & sw_wr & (kind == K_FPC);
            assign wr_fst = hit & sw_wr & (kind == K_FST);
            assign wr_psw = hit & sw_wr & (kind == K_PSW);

            // hardware save beats a software write in the same cycle
            assign next_mpc = (hit & mexc_ack_i) ? exc_pc
                            : wr_mpc ? acc_wdata_i : mpc_q[g];
            assign next_mst = (hit & mexc_ack_i) ? psw_cur
                            : wr_mst ? acc_wdata_i : mst_q[g];
            assign next_fpc = (hit & fexc_ack_i) ? exc_pc
                            : wr_fpc ? acc_wdata_i : fpc_q[g];
            assign next_fst = (hit & fexc_ack_i) ? psw_cur
                            : wr_fst ? acc_wdata_i : fst_q[g];

            // software merge first, then execution flags override them
            assign psw_sw   = wr_psw ? ((psw_q[g] & ~psw_mask)
                                     | (acc_wdata_i & psw_mask))
                            : psw_q[g];
            assign next_psw = (hit & flags_we_i)
                            ? ((psw_sw & ~PSW_FLAGS) | flag_word)
                            : psw_sw;

            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    mpc_q[g] <= WORD_RST;
                    mst_q[g] <= WORD_RST;
                    fpc_q[g] <= WORD_RST;
                    fst_q[g] <= WORD_RST;
                    psw_q[g] <= PSW_RST;
                end else begin
                    mpc_q[g] <= next_mpc;
                    mst_q[g] <= next_mst;
                    fpc_q[g] <= next_fpc;
                    fst_q[g] <= next_fst;
                    psw_q[g] <= next_psw;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // plain registers live in the word memory
    wire logic        mem_we;
    wire logic [31:0] mem_rdata;

    assign mem_we = sw_wr & (kind == K_MEM);

    vsr_regmem u_mem (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .we_i      (mem_we),
        .addr_i    (mem_idx),
        .wdata_i   (acc_wdata_i),
        .rdata_o   (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // value of the selected special register at request time
    wire logic [31:0] spec_val;

    assign spec_val = (kind == K_MPC) ? mpc_q[ctx]
                    : (kind == K_MST) ? mst_q[ctx]
                    : (kind == K_FPC) ? fpc_q[ctx]
                    : (kind == K_FST) ? fst_q[ctx]
                    : (kind == K_PSW) ? psw_cur
                    : (kind == K_ID)  ? IDENT_VAL
                    : WORD_RST;

    ////////////////////////////////////////////////////////////////////////
    // first stage: catch the request, matching the memory read latency
    logic        req_q;
    logic        deny_q;
    logic        rd_ok_q;
    logic        is_mem_q;
    logic [31:0] spec_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_q    <= 1'b0;
            deny_q   <= 1'b0;
            rd_ok_q  <= 1'b0;
            is_mem_q <= 1'b0;
            spec_q   <= WORD_RST;
        end else begin
            req_q    <= acc_req_i;
            deny_q   <= acc_req_i & mapped & ~priv_ok;
            rd_ok_q  <= acc_req_i & ~acc_we_i & mapped & priv_ok;
            is_mem_q <= (kind == K_MEM);
            spec_q   <= spec_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // answer stage: refused or unmapped reads return zero
    wire logic [31:0] next_rd_data;

    assign next_rd_data = !rd_ok_q ? WORD_RST
                        : is_mem_q ? mem_rdata
                        : spec_q;

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o    <= 1'b0;
            denied_o  <= 1'b0;
            rd_data_o <= WORD_RST;
        end else begin
            done_o    <= req_q;
            denied_o  <= deny_q;
            rd_data_o <= next_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // both status words leave from their own flops
    assign host_program_status_o  = psw_q[0];
    assign guest_program_status_o = psw_q[1];

endmodule
`default_nettype wire

/* File: pkg/vsr_pkg.sv */
`default_nettype none
package vsr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // privilege levels, ordered so a plain compare decides authority
    localparam logic [1:0] PRIV_USER = 2'h0;
    localparam logic [1:0] PRIV_SUP  = 2'h1;
    localparam logic [1:0] PRIV_HYP  = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // register keys: {selection group, register number}
    localparam logic [9:0] A_MEXC_PC   = 10'h000;
    localparam logic [9:0] A_MEXC_ST   = 10'h001;
    localparam logic [9:0] A_FEXC_PC   = 10'h002;
    localparam logic [9:0] A_FEXC_ST   = 10'h003;
    localparam logic [9:0] A_PSW       = 10'h005;
    localparam logic [9:0] A_MEXC_CA   = 10'h00d;
    localparam logic [9:0] A_FEXC_CA   = 10'h00e;
    localparam logic [9:0] A_CT_PC     = 10'h010;
    localparam logic [9:0] A_CT_ST     = 10'h011;
    localparam logic [9:0] A_CT_BASE   = 10'h014;
    localparam logic [9:0] A_SNOOZE    = 10'h015;
    localparam logic [9:0] A_MEXC_WR   = 10'h01c;
    localparam logic [9:0] A_FEXC_WR   = 10'h01d;
    localparam logic [9:0] A_GRP_ID    = 10'h020;
    localparam logic [9:0] A_GRP_LIST  = 10'h021;
    localparam logic [9:0] A_RST_VEC   = 10'h022;
    localparam logic [9:0] A_EXC_VEC   = 10'h023;
    localparam logic [9:0] A_INT_TBL   = 10'h024;
    localparam logic [9:0] A_MCTRL     = 10'h025;
    localparam logic [9:0] A_IDENT     = 10'h026;
    localparam logic [9:0] A_SV_LOCK   = 10'h028;
    localparam logic [9:0] A_SC_CFG    = 10'h02b;
    localparam logic [9:0] A_SC_BASE   = 10'h02c;
    localparam logic [9:0] A_CORE_NUM  = 10'h040;
    localparam logic [9:0] A_BUSM_NUM  = 10'h041;
    localparam logic [9:0] A_MERR_ADR  = 10'h046;
    localparam logic [9:0] A_MERR_INF  = 10'h048;
    localparam logic [9:0] A_BANK_C0   = 10'h04f;
    localparam logic [9:0] A_BANK_C1   = 10'h050;
    localparam logic [9:0] A_BANK_NUM  = 10'h051;
    localparam logic [9:0] A_BANK_IP   = 10'h052;

    ////////////////////////////////////////////////////////////////////////
    // storage kinds
    localparam logic [2:0] K_NONE = 3'h0;
    localparam logic [2:0] K_MEM  = 3'h1;
    localparam logic [2:0] K_MPC  = 3'h2;
    localparam logic [2:0] K_MST  = 3'h3;
    localparam logic [2:0] K_FPC  = 3'h4;
    localparam logic [2:0] K_FST  = 3'h5;
    localparam logic [2:0] K_PSW  = 3'h6;
    localparam logic [2:0] K_ID   = 3'h7;

    localparam int          MEM_DEPTH = 32;
    localparam logic [31:0] WORD_RST  = 32'h0000_0000;
    // execution result flags occupy the low bits of the status word
    localparam logic [31:0] PSW_FLAGS = 32'h0000_001f;
    localparam logic [31:0] PSW_RST   = 32'h0000_0020;
    // identity value is arbitrary
    localparam logic [31:0] IDENT_VAL = 32'h5a80_0000;

    // result: {kind, memory index, required privilege}
    function automatic logic [9:0] vsr_decode(input logic [9:0] key);
        logic [9:0] r;
        r = {K_NONE, 5'h00, PRIV_HYP};
        case (key)
            A_MEXC_PC:  r = {K_MPC, 5'h00, PRIV_SUP};
            A_MEXC_ST:  r = {K_MST, 5'h00, PRIV_SUP};
            A_FEXC_PC:  r = {K_FPC, 5'h00, PRIV_SUP};
            A_FEXC_ST:  r = {K_FST, 5'h00, PRIV_SUP};
            A_PSW:      r = {K_PSW, 5'h00, PRIV_USER};
            A_MEXC_CA:  r = {K_MEM, 5'h00, PRIV_SUP};
            A_FEXC_CA:  r = {K_MEM, 5'h01, PRIV_SUP};
            A_CT_PC:    r = {K_MEM, 5'h02, PRIV_USER};
            A_CT_ST:    r = {K_MEM, 5'h03, PRIV_USER};
            A_CT_BASE:  r = {K_MEM, 5'h04, PRIV_USER};
            A_SNOOZE:   r = {K_MEM, 5'h05, PRIV_HYP};
            A_MEXC_WR:  r = {K_MEM, 5'h06, PRIV_SUP};
            A_FEXC_WR:  r = {K_MEM, 5'h07, PRIV_SUP};
            A_GRP_ID:   r = {K_MEM, 5'h08, PRIV_SUP};
            A_GRP_LIST: r = {K_MEM, 5'h09, PRIV_SUP};
            A_RST_VEC:  r = {K_MEM, 5'h0a, PRIV_SUP};
            A_EXC_VEC:  r = {K_MEM, 5'h0b, PRIV_SUP};
            A_INT_TBL:  r = {K_MEM, 5'h0c, PRIV_SUP};
            A_MCTRL:    r = {K_MEM, 5'h0d, PRIV_SUP};
            A_IDENT:    r = {K_ID,  5'h00, PRIV_SUP};
            A_SV_LOCK:  r = {K_MEM, 5'h0e, PRIV_SUP};
            A_SC_CFG:   r = {K_MEM, 5'h0f, PRIV_SUP};
            A_SC_BASE:  r = {K_MEM, 5'h10, PRIV_SUP};
            A_CORE_NUM: r = {K_MEM, 5'h11, PRIV_USER};
            A_BUSM_NUM: r = {K_MEM, 5'h12, PRIV_USER};
            A_MERR_ADR: r = {K_MEM, 5'h13, PRIV_SUP};
            A_MERR_INF: r = {K_MEM, 5'h14, PRIV_SUP};
            A_BANK_C0:  r = {K_MEM, 5'h15, PRIV_SUP};
            A_BANK_C1:  r = {K_MEM, 5'h16, PRIV_SUP};
            A_BANK_NUM: r = {K_MEM, 5'h17, PRIV_SUP};
            A_BANK_IP:  r = {K_MEM, 5'h18, PRIV_SUP};
            default:    r = {K_NONE, 5'h00, PRIV_HYP};
        endcase
        return r;
    endfunction

endpackage
`default_nettype wire

/* File: design/vsr_regmem.sv */
`timescale 1ns/10ps
`default_nettype none
module vsr_regmem
    import vsr_pkg::*;
(
    input  wire logic        ref_clk_i,  // core clock
    input  wire logic        rstn_i,     // async reset, active low
    input  wire logic        we_i,       // write strobe
    input  wire logic [4:0]  addr_i,     // word index
    input  wire logic [31:0] wdata_i,    // write data
    output logic      [31:0] rdata_o     // registered read data
);

    logic [31:0] mem [MEM_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // every word resets so software never reads an undefined value
    genvar i;
    generate
        for (i = 0; i < MEM_DEPTH; i++) begin : g_word
            always_ff @(posedge ref_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    mem[i] <= WORD_RST;
                end else if (we_i && (addr_i == 5'(i))) begin
                    mem[i] <= wdata_i;
                end
            end
        end
    endgenerate

    // read returns the value before a same-edge write
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= WORD_RST;
        end else begin
            rdata_o <= mem[addr_i];
        end
    end

endmodule
`default_nettype wire

/* File: bench/vsr_pipe_model.sv */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// pipeline side: holds the address of the instruction in flight
module vsr_pipe_model (
    input  wire logic        ref_clk_i, // core clock
    input  wire logic        rstn_i,    // async reset, active low
    input  wire logic        load_i,    // jump to a new address
    input  wire logic [31:0] addr_i,    // jump target
    output logic      [31:0] pc_cur_o,  // instruction in flight
    output logic      [31:0] pc_next_o  // following instruction
);
    // fixed 4-byte step; variable-length fetch is not modelled
    assign pc_next_o = pc_cur_o + 32'h0000_0004;
    // address register, only moved by a jump
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pc_cur_o <= 32'h0000_0000;
        end else if (load_i) begin
            pc_cur_o <= addr_i;
        end
    end
endmodule
`default_nettype wire

/* File: bench/vsr_sysreg_bank_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module vsr_sysreg_bank_properties
    import vsr_pkg::*;
(
    input wire logic        ref_clk_i,             // core clock
    input wire logic        rstn_i,                // async reset, active low
    input wire logic        acc_req_i,             // access request
    input wire logic        acc_we_i,              // write
    input wire logic [4:0]  acc_regid_i,           // register number
    input wire logic [4:0]  acc_selid_i,           // selection group
    input wire logic [1:0]  acc_priv_i,            // privilege
    input wire logic        guest_mode_i,          // guest mode
    input wire logic        virt_enable_i,         // virtualization on
    input wire logic        mexc_ack_i,            // maskable ack
    input wire logic        fexc_ack_i,            // fatal ack
    input wire logic        flags_we_i,            // flag update
    input wire logic [4:0]  flags_i,               // new flags
    input wire logic        done_o,                // answer
    input wire logic        denied_o,              // refused
    input wire logic [31:0] rd_data_o,             // read data
    input wire logic [31:0] host_program_status_o, // host word
    input wire logic [31:0] guest_program_status_o // guest word
);
    wire logic [9:0] key;
    // key as the bank decodes it
    assign key = {acc_selid_i, acc_regid_i};
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    ////////////////////////////////////////////////////////////////////
    a_done_two_later: assert property (acc_req_i |-> ##2 done_o)
        else $error("no answer two cycles after request");
    a_done_has_cause: assert property (done_o |-> $past(acc_req_i, 2))
        else $error("answer without request");
    a_denied_zero: assert property (denied_o |-> done_o && rd_data_o == 32'h0)
        else $error("refusal without answer or with data");
    a_fatal_priv: assert property (acc_req_i && (key == A_FEXC_PC || key == A_FEXC_ST)
        && acc_priv_i < PRIV_SUP |-> ##2 denied_o) else $error("fatal save open to user");
    a_list_priv: assert property (acc_req_i && key == A_GRP_LIST |-> ##2
        (denied_o == ($past(acc_priv_i, 2) < PRIV_SUP))) else $error("group list authority");
    a_psw_user_read: assert property (acc_req_i && !acc_we_i && key == A_PSW
        |-> ##2 !denied_o) else $error("status word read refused");
    a_snooze_hyp: assert property (acc_req_i && key == A_SNOOZE && virt_enable_i
        && acc_priv_i == PRIV_SUP |-> ##2 denied_o) else $error("snooze open to supervisor");
    a_flags_host: assert property (flags_we_i && !guest_mode_i |=>
        host_program_status_o[4:0] == $past(flags_i)) else $error("host flags not updated");
    a_guest_kept: assert property (flags_we_i && !guest_mode_i && !mexc_ack_i && !fexc_ack_i
        |=> $stable(guest_program_status_o)) else $error("guest word changed in host");
endmodule
// bank ports are watched by name
bind vsr_sysreg_bank vsr_sysreg_bank_properties u_props (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .acc_req_i(acc_req_i), .acc_we_i(acc_we_i),
    .acc_regid_i(acc_regid_i), .acc_selid_i(acc_selid_i), .acc_priv_i(acc_priv_i),
    .guest_mode_i(guest_mode_i), .virt_enable_i(virt_enable_i), .mexc_ack_i(mexc_ack_i),
    .fexc_ack_i(fexc_ack_i), .flags_we_i(flags_we_i), .flags_i(flags_i), .done_o(done_o),
    .denied_o(denied_o), .rd_data_o(rd_data_o), .host_program_status_o(host_program_status_o),
    .guest_program_status_o(guest_program_status_o));
`default_nettype wire

/* File: bench/vsr_sysreg_bank_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module vsr_sysreg_bank_bench
    import vsr_pkg::*;
;
    typedef struct {logic we; logic gm; logic [9:0] key; logic [31:0] wd;
                    logic [1:0] pv; logic [31:0] ed; logic en;} vsr_row_type;
    logic        clk = 1'b0, rstn = 1'b0, req = 1'b0, we = 1'b0, gm = 1'b0, ve = 1'b0;
    logic        mack = 1'b0, fack = 1'b0, sel = 1'b0, fwe = 1'b0, ld = 1'b0;
    logic [9:0]  key = 10'h000;
    logic [31:0] wd = 32'h0, ldpc = 32'h0, rd;
    logic [1:0]  pv = 2'h0;
    logic [4:0]  fl = 5'h00;
    logic        dn;
    wire  logic        done, den;
    wire  logic [31:0] rdo, hps, gps, pcc, pcn;
    int          errors = 0, checked = 0, cyc = 0;
    vsr_row_type rows [24] = '{
        '{1, 0, A_CT_BASE, 32'h1234, PRIV_USER, 0, 0}, '{0, 0, A_CT_BASE, 0, PRIV_USER, 32'h1234, 0},
        '{1, 0, A_FEXC_PC, 32'h55, PRIV_USER, 0, 1}, '{0, 0, A_FEXC_PC, 0, PRIV_USER, 0, 1},
        '{1, 0, A_FEXC_PC, 32'ha5, PRIV_SUP, 0, 0}, '{0, 0, A_FEXC_PC, 0, PRIV_SUP, 32'ha5, 0},
        '{0, 0, A_FEXC_ST, 0, PRIV_USER, 0, 1}, '{1, 0, A_GRP_LIST, 32'hf0, PRIV_SUP, 0, 0},
        '{0, 0, A_GRP_LIST, 0, PRIV_USER, 0, 1}, '{0, 0, A_GRP_LIST, 0, PRIV_SUP, 32'hf0, 0},
        '{1, 0, A_IDENT, 0, PRIV_SUP, 0, 0}, '{0, 0, A_IDENT, 0, PRIV_SUP, IDENT_VAL, 0},
        '{0, 0, 10'h3ff, 0, PRIV_HYP, 0, 0}, '{1, 0, A_PSW, 32'hffff_ffff, PRIV_USER, 0, 0},
        '{0, 0, A_PSW, 0, PRIV_USER, 32'h3f, 0}, '{1, 0, A_PSW, 32'h100, PRIV_SUP, 0, 0},
        '{0, 0, A_PSW, 0, PRIV_USER, 32'h100, 0}, '{1, 0, A_MEXC_PC, 32'h11, PRIV_SUP, 0, 0},
        '{1, 1, A_MEXC_PC, 32'h22, PRIV_SUP, 0, 0}, '{0, 0, A_MEXC_PC, 0, PRIV_SUP, 32'h11, 0},
        '{0, 1, A_MEXC_PC, 0, PRIV_SUP, 32'h22, 0}, '{0, 0, A_GRP_ID, 0, PRIV_USER, 0, 1},
        '{1, 0, A_SNOOZE, 32'h7, PRIV_SUP, 0, 0}, '{0, 0, A_SNOOZE, 0, PRIV_SUP, 32'h7, 0}};
    always #25 clk = ~clk;
    vsr_pipe_model u_vsr_pipe_model (.ref_clk_i(clk), .rstn_i(rstn), .load_i(ld), .addr_i(ldpc),
        .pc_cur_o(pcc), .pc_next_o(pcn));
    vsr_sysreg_bank u_vsr_sysreg_bank (.ref_clk_i(clk), .rstn_i(rstn), .acc_req_i(req),
        .acc_we_i(we), .acc_regid_i(key[4:0]), .acc_selid_i(key[9:5]), .acc_wdata_i(wd),
        .acc_priv_i(pv), .guest_mode_i(gm), .virt_enable_i(ve), .mexc_ack_i(mack),
        .fexc_ack_i(fack), .pc_cur_i(pcc), .pc_next_i(pcn), .pc_sel_next_i(sel),
        .flags_we_i(fwe), .flags_i(fl), .done_o(done), .denied_o(den), .rd_data_o(rdo),
        .host_program_status_o(hps), .guest_program_status_o(gps));
    ////////////////////////////////////////////////////////////////////
    // four-state compares, so an unknown never matches
    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one access; the answer stands only in the cycle two edges on
    task automatic acc(input logic w, input logic g, input logic [9:0] k, input logic [31:0] d,
                       input logic [1:0] p, output logic [31:0] r, output logic n);
        @(negedge clk);
        {req, we, gm, key, wd, pv} = {1'b1, w, g, k, d, p};
        @(negedge clk);
        req = 1'b0;
        // taken at the edge just passed; answer stands in the cycle after the next edge
        @(negedge clk);
        cmp1(done, 1'b1);
        r = rdo;
        n = den;
    endtask
    // a fixed ceiling turns a hang into a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        cmp32(hps, PSW_RST);
        cmp32(gps, PSW_RST);
        cmp1(done, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            acc(rows[i].we, rows[i].gm, rows[i].key, rows[i].wd, rows[i].pv, rd, dn);
            cmp32(rd, rows[i].ed);
            cmp1(dn, rows[i].en);
        end
        $display("test table done");
        ve = 1'b1;
        acc(1'b1, 1'b0, A_SNOOZE, 32'h9, PRIV_SUP, rd, dn);
        cmp1(dn, 1'b1);
        acc(1'b0, 1'b0, A_SNOOZE, 32'h0, PRIV_HYP, rd, dn);
        cmp32(rd, 32'h7);
        $display("test snooze done");
        @(negedge clk);
        {fwe, fl, gm} = {1'b1, 5'h0a, 1'b0};
        @(negedge clk);
        fwe = 1'b0;
        cmp32(hps, 32'h10a);
        cmp32(gps, PSW_RST);
        $display("test flags done");
        {ld, ldpc} = {1'b1, 32'h1000};
        @(negedge clk);
        {ld, mack, sel} = 3'b110;
        @(negedge clk);
        mack = 1'b0;
        acc(1'b0, 1'b0, A_MEXC_PC, 32'h0, PRIV_SUP, rd, dn);
        cmp32(rd, 32'h1000);
        acc(1'b0, 1'b0, A_MEXC_ST, 32'h0, PRIV_SUP, rd, dn);
        cmp32(rd, 32'h10a);
        @(negedge clk);
        {gm, fack, sel} = 3'b111;
        @(negedge clk);
        fack = 1'b0;
        acc(1'b0, 1'b1, A_FEXC_PC, 32'h0, PRIV_SUP, rd, dn);
        cmp32(rd, 32'h1004);
        acc(1'b0, 1'b1, A_FEXC_ST, 32'h0, PRIV_SUP, rd, dn);
        cmp32(rd, PSW_RST);
        acc(1'b0, 1'b0, A_FEXC_PC, 32'h0, PRIV_SUP, rd, dn);
        cmp32(rd, 32'ha5);
        $display("test exceptions done");
        test_done();
    end
endmodule
`default_nettype wire
